// ===== pkg/lsb_pkg.sv
// Package for the LED sink blink and fade timing block
package lsb_pkg;
   // ********************
   // Timing constants
   // ********************
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int BLINK_TICK_MS = 100;
   localparam logic [6:0] FULL_SCALE = 7'h7f;
   localparam int FULL_SCALE_STEPS = 127;

   // ********************
   // Register map
   // ********************
   localparam logic [7:0] OFF_TIME_ADDR = 8'h12;
   localparam logic [7:0] FADE_RATE_ADDR = 8'h13;
   localparam logic [7:0] OFF_TIME_RESET = 8'h00;
   localparam logic [7:0] FADE_RATE_RESET = 8'h00;
   localparam int OFF_FIELD_W = 2;
   localparam int FADE_OUT_LSB = 4;
   localparam int FADE_IN_LSB = 0;
   localparam int FADE_FIELD_W = 4;
   localparam int NUM_SINKS = 4;

   // ********************
   // Types
   // ********************
   typedef enum logic {LSB_PH_ON = 1'b0, LSB_PH_OFF = 1'b1} lsb_phase_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lsb_reg_req_t;

   typedef struct packed {
      lsb_phase_t phase;
      logic [4:0] ticks;
      logic [6:0] cur;
      logic on;
   } lsb_sink_t;

   typedef struct packed {
      logic [7:0] off_reg;
      logic [7:0] fade_reg;
      logic [7:0] rdata;
      logic [31:0] tick_cnt;
      logic tick;
      logic [31:0] fin_cnt;
      logic [31:0] fout_cnt;
      logic fin_step;
      logic fout_step;
      lsb_sink_t [3:0] sink;
   } lsb_state_t;

   // Off time in 0.1 s ticks; zero means steady on
   function automatic logic [4:0] lsb_off_ticks(input logic [1:0] code);
      case (code)
         2'h1: lsb_off_ticks = 5'h06;
         2'h2: lsb_off_ticks = 5'h0c;
         2'h3: lsb_off_ticks = 5'h12;
         default: lsb_off_ticks = 5'h00;
      endcase
   endfunction

   // Shared on time in 0.1 s ticks
   function automatic logic [4:0] lsb_on_ticks(input logic [1:0] code);
      case (code)
         2'h0: lsb_on_ticks = 5'h02;
         2'h1: lsb_on_ticks = 5'h06;
         2'h2: lsb_on_ticks = 5'h08;
         default: lsb_on_ticks = 5'h0c;
      endcase
   endfunction

   // Full-scale fade duration in ms; zero means no fade
   function automatic int lsb_fade_ms(input logic [3:0] code);
      if (code == 4'h0)
         lsb_fade_ms = 0;
      else if (code <= 4'ha)
         lsb_fade_ms = 300 * int'(code);
      else
         lsb_fade_ms = 3000 + 500 * (int'(code) - 10);
   endfunction
endpackage

// ===== hdl/lsb_timing.sv
// LED sink blink off-time and fade-rate timing block
import lsb_pkg::*;

// Contract
// - Sink 4 off-time code sits in bits 7:6 of register 0x12.
// - Sink 3 off-time code sits in bits 5:4 of register 0x12.
// - Sink 2 off-time code sits in bits 3:2 of register 0x12.
// - Sink 1 off-time code sits in bits 1:0 of register 0x12.
// - Off code: 00 no blink, 01 0.6 s, 10 1.2 s, 11 1.8 s.
// - Off code 00 keeps the sink steadily on while enabled.
// - Nonzero off code alternates off time and shared on time.
// - Fade-out code is bits 7:4 of register 0x13; 0000 disables.
// - Fade codes 1-10 give 0.3-3.0 s, 11-15 give 3.5-5.5 s.
// - Fade-in code is bits 3:0 of register 0x13; 0000 disables.
// - Fade-in uses the same table, timed for a zero to full ramp.
// - Ramp rate is fixed, so shorter fades take less time.
// - Shared on time: 00 0.2 s, 01 0.6, 10 0.8, 11 1.2 s.
// - A sink runs only while its enable is set; clear means off.
module lsb_timing #(
   parameter int CYC_MS = lsb_pkg::CYC_PER_MS // cycles per millisecond
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic sys_rst, // async reset, active high
   input wire lsb_pkg::lsb_reg_req_t reg_req, // register write port
   output logic [7:0] reg_rdata, // register read data
   input wire logic [3:0] sink_enable, // per-sink enable
   input wire logic [1:0] blink_on_time, // shared on-time code
   input wire logic [3:0][6:0] sink_level, // per-sink on current code
   output logic [3:0] sink_on, // sink in its on phase
   output logic [3:0][6:0] sink_current // present current code
);
   import lsb_pkg::*;

   localparam int TICK_CYC = BLINK_TICK_MS * CYC_MS;

   lsb_state_t st;
   lsb_state_t next_st;

   // Cycles per one-code step for a fade code
   function automatic logic [31:0] step_cyc(input logic [3:0] code);
      int c;
      c = lsb_fade_ms(code) * CYC_MS / FULL_SCALE_STEPS;
      step_cyc = (c < 1) ? 32'h1 : 32'(c);
   endfunction

   logic [3:0] fout_code;
   logic [3:0] fin_code;

   assign fout_code = st.fade_reg[FADE_OUT_LSB +: FADE_FIELD_W];
   assign fin_code = st.fade_reg[FADE_IN_LSB +: FADE_FIELD_W];

   // ********************
   // Next state
   // ********************
   always_comb begin
      logic [1:0] off_code;
      logic [4:0] limit;
      logic [6:0] target;
      next_st = st;
      off_code = 2'h0;
      limit = 5'h00;
      target = 7'h00;
      next_st.rdata = 8'h00;
      if (reg_req.addr == OFF_TIME_ADDR) begin
         next_st.rdata = st.off_reg;
      end else if (reg_req.addr == FADE_RATE_ADDR) begin
         next_st.rdata = st.fade_reg;
      end
      if (reg_req.we && reg_req.addr == OFF_TIME_ADDR) begin
         next_st.off_reg = reg_req.wdata;
      end
      if (reg_req.we && reg_req.addr == FADE_RATE_ADDR) begin
         next_st.fade_reg = reg_req.wdata;
      end
      // Blink timebase, one pulse per 0.1 s
      next_st.tick = 1'b0;
      if (st.tick_cnt >= 32'(TICK_CYC - 1)) begin
         next_st.tick_cnt = 32'h0;
         next_st.tick = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 32'h1;
      end
      next_st.fout_step = 1'b0;
      if (fout_code == 4'h0) begin
         next_st.fout_cnt = 32'h0;
      end else if (st.fout_cnt >= step_cyc(fout_code) - 32'h1) begin
         next_st.fout_cnt = 32'h0;
         next_st.fout_step = 1'b1;
      end else begin
         next_st.fout_cnt = st.fout_cnt + 32'h1;
      end
      next_st.fin_step = 1'b0;
      if (fin_code == 4'h0) begin
         next_st.fin_cnt = 32'h0;
      end else if (st.fin_cnt >= step_cyc(fin_code) - 32'h1) begin
         next_st.fin_cnt = 32'h0;
         next_st.fin_step = 1'b1;
      end else begin
         next_st.fin_cnt = st.fin_cnt + 32'h1;
      end
      for (int i = 0; i < NUM_SINKS; i++) begin
         off_code = st.off_reg[i*OFF_FIELD_W +: OFF_FIELD_W];
         // disabled or steady sinks sit in on phase
         if (!sink_enable[i] || off_code == 2'h0) begin
            next_st.sink[i].phase = LSB_PH_ON;
            next_st.sink[i].ticks = 5'h00;
         end else if (st.tick) begin
            limit = (st.sink[i].phase == LSB_PH_ON) ?
               lsb_on_ticks(blink_on_time) : lsb_off_ticks(off_code);
            if (st.sink[i].ticks + 5'h01 >= limit) begin
               next_st.sink[i].ticks = 5'h00;
               next_st.sink[i].phase = (st.sink[i].phase == LSB_PH_ON) ?
                  LSB_PH_OFF : LSB_PH_ON;
            end else begin
               next_st.sink[i].ticks = st.sink[i].ticks + 5'h01;
            end
         end
         next_st.sink[i].on = sink_enable[i] &&
            next_st.sink[i].phase == LSB_PH_ON;
         target = next_st.sink[i].on ? sink_level[i] : 7'h00;
         // one code per step, fixed rate
         if (st.sink[i].cur < target) begin
            if (fin_code == 4'h0) begin
               next_st.sink[i].cur = target;
            end else if (st.fin_step) begin
               next_st.sink[i].cur = st.sink[i].cur + 7'h01;
            end
         end else if (st.sink[i].cur > target) begin
            if (fout_code == 4'h0) begin
               next_st.sink[i].cur = target;
            end else if (st.fout_step) begin
               next_st.sink[i].cur = st.sink[i].cur - 7'h01;
            end
         end
      end
   end

   // ********************
   // State register
   // ********************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.off_reg <= OFF_TIME_RESET;
         st.fade_reg <= FADE_RATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   always_comb begin
      for (int i = 0; i < NUM_SINKS; i++) begin
         sink_on[i] = st.sink[i].on;
         sink_current[i] = st.sink[i].cur;
      end
   end

   // ********************
   // Assertions
   // ********************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_off_write;
      reg_req.we && reg_req.addr == OFF_TIME_ADDR;
   endsequence

   a_sink4_field: assert property (
      s_off_write |=> st.off_reg[7:6] == $past(reg_req.wdata[7:6]))
      else $error("sink4 off field not stored");
   a_sink3_field: assert property (
      s_off_write |=> st.off_reg[5:4] == $past(reg_req.wdata[5:4]))
      else $error("sink3 off field not stored");
   a_sink2_field: assert property (
      s_off_write |=> st.off_reg[3:2] == $past(reg_req.wdata[3:2]))
      else $error("sink2 off field not stored");
   a_sink1_field: assert property (
      s_off_write |=> st.off_reg[1:0] == $past(reg_req.wdata[1:0]))
      else $error("sink1 off field not stored");
   a_fade_fields: assert property (
      reg_req.we && reg_req.addr == FADE_RATE_ADDR |=>
      fout_code == $past(reg_req.wdata[7:4]) &&
      fin_code == $past(reg_req.wdata[3:0]))
      else $error("fade fields not stored");
   a_steady_on: assert property (
      sink_enable[0] && st.off_reg[1:0] == 2'h0 |=> sink_on[0])
      else $error("steady sink not on");
   a_disable_off: assert property (
      !sink_enable[0] |=> !sink_on[0])
      else $error("disabled sink still on");
   // Sink 4 is the one whose on time the bench sweeps, so the phase checks watch it
   a_off_phase_len: assert property (
      st.tick && st.sink[3].phase == LSB_PH_OFF && sink_enable[3] &&
      st.off_reg[7:6] != 2'h0 && st.sink[3].ticks <
      lsb_off_ticks(st.off_reg[7:6]) - 5'h01 |=>
      st.sink[3].phase == LSB_PH_OFF)
      else $error("off phase ended early");
   a_blink_toggle: assert property (
      st.tick && sink_enable[3] && st.off_reg[7:6] != 2'h0 &&
      st.sink[3].phase == LSB_PH_ON && $stable(sink_enable[3]) &&
      st.sink[3].ticks + 5'h01 >= lsb_on_ticks(blink_on_time) |=>
      st.sink[3].phase == LSB_PH_OFF)
      else $error("on phase did not end");
   a_jump_no_fade: assert property (
      fin_code == 4'h0 && fout_code == 4'h0 |=>
      sink_current[0] == (st.sink[0].on ? $past(sink_level[0]) : 7'h00))
      else $error("current did not jump");
   a_step_one: assert property (
      sink_current[0] != $past(sink_current[0]) && fin_code != 4'h0 &&
      fout_code != 4'h0 && $stable(st.fade_reg) |->
      (sink_current[0] - $past(sink_current[0]) == 7'h01 ||
      $past(sink_current[0]) - sink_current[0] == 7'h01))
      else $error("fade moved more than one code");
endmodule // lsb_timing

// ===== sim/lsb_led_model.sv
// Behavioural LED load hanging on the four current sinks
module lsb_led_model (
   input wire logic sys_clk, // clock
   input wire logic [3:0][6:0] sink_current, // drive code per sink
   output logic [3:0] lit, // LED gives light
   output logic [3:0] peak // LED at full scale
);
   import lsb_pkg::*;
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < NUM_SINKS; i++) begin
         lit[i] <= sink_current[i] != 7'h00;
         peak[i] <= sink_current[i] == FULL_SCALE;
      end
   end
endmodule // lsb_led_model

// ===== sim/lsb_timing_tb_top.sv
// Self-checking testbench for the LED sink timing block
module lsb_timing_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lsb_pkg::*;
   localparam int CM = 2;
   localparam int TK = BLINK_TICK_MS * CM;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   lsb_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata, rd;
   logic [3:0] sink_enable = 4'h0;
   logic [1:0] blink_on_time = 2'h0;
   logic [3:0][6:0] sink_level = {4{7'h7f}};
   logic [3:0] sink_on, lit, peak;
   logic [3:0][6:0] sink_current;
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   int on_t, off_t, t;
   int ontk[4] = '{2, 6, 8, 12};
   lsb_timing #(.CYC_MS(CM)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .sink_enable(sink_enable),
      .blink_on_time(blink_on_time), .sink_level(sink_level),
      .sink_on(sink_on), .sink_current(sink_current));
   lsb_led_model led (.sys_clk(sys_clk), .sink_current(sink_current),
      .lit(lit), .peak(peak));
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(negedge sys_clk);
      reg_req = '{we: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk);
      reg_req.we = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_req.addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   // Lengths in ticks of one fresh off phase and the on phase after it
   task automatic blink(input int i, output int on_n, off_n);
      int n;
      n = 0;
      while (sink_on[i] !== 1'b1) @(negedge sys_clk);
      while (sink_on[i] === 1'b1) @(negedge sys_clk);
      while (sink_on[i] !== 1'b1) begin
         n++;
         @(negedge sys_clk);
      end
      off_n = (n + TK / 2) / TK;
      n = 0;
      while (sink_on[i] === 1'b1) begin
         n++;
         @(negedge sys_clk);
      end
      on_n = (n + TK / 2) / TK;
   endtask
   task automatic ramp(input int i, input logic [6:0] lv, output int n);
      n = 0;
      while (sink_current[i] !== lv) begin
         n++;
         @(negedge sys_clk);
      end
   endtask
   function automatic int fms(input int c);
      return (c <= 10) ? 300 * c : 3000 + 500 * (c - 10);
   endfunction
   // Ramp length in steps must match the step count within one step
   task automatic fchk(input string nm, input int n, c, s);
      int p, r;
      p = fms(c) * CM / FULL_SCALE_STEPS;
      r = (n + p / 2) / p;
      chk(nm, 32'(r >= s - 1 && r <= s + 1), 32'h1);
   endtask
   // ********************
   // Scenarios
   // ********************
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      rdr(OFF_TIME_ADDR, rd);
      chk("off_reset", rd, OFF_TIME_RESET);
      rdr(FADE_RATE_ADDR, rd);
      chk("fade_reset", rd, FADE_RATE_RESET);
      wr(8'h14, 8'h5a);
      rdr(8'h14, rd);
      chk("unmapped", rd, 8'h00);
      sink_enable = 4'hf;
      repeat (3) @(negedge sys_clk);
      chk("steady_on", sink_on, 4'hf);
      chk("jump_on", sink_current, {4{7'h7f}});
      chk("led_lit", lit, 4'hf);
      wr(OFF_TIME_ADDR, 8'h78);
      rdr(OFF_TIME_ADDR, rd);
      chk("off_reg", rd, 8'h78);
      for (int c = 0; c < 4; c++) begin
         blink_on_time = 2'(c);
         blink(3, on_t, off_t);
         chk("on_time", on_t, ontk[c]);
         chk("off_sink4", off_t, 6);
      end
      for (int i = 1; i < 3; i++) begin
         blink(i, on_t, off_t);
         chk("off_time", off_t, (i + 1) * 6);
      end
      chk("steady_sink1", sink_on[0], 1'b1);
      sink_enable = 4'h6;
      repeat (3) @(negedge sys_clk);
      chk("dis_on", {sink_on[3], sink_on[0]}, 2'h0);
      chk("dis_cur", sink_current[0], 7'h00);
      wr(FADE_RATE_ADDR, 8'h21);
      sink_enable[0] = 1'b1;
      ramp(0, 7'h7f, t);
      fchk("fade_full", t, 1, 127);
      // LED load registers the drive code one edge later
      @(negedge sys_clk);
      chk("led_peak", peak[0], 1'b1);
      sink_level[0] = 7'h3f;
      ramp(0, 7'h3f, t);
      fchk("fade_part", t, 2, 64);
      sink_enable[0] = 1'b0;
      ramp(0, 7'h00, t);
      fchk("fade_off", t, 2, 63);
      sink_level[0] = 7'h10;
      for (int c = 1; c < 16; c++) begin
         wr(FADE_RATE_ADDR, {4'(c), 4'(c)});
         rdr(FADE_RATE_ADDR, rd);
         chk("fade_reg", rd, {4'(c), 4'(c)});
         sink_enable[0] = 1'b1;
         ramp(0, 7'h10, t);
         fchk("fade_in", t, c, 16);
         sink_enable[0] = 1'b0;
         ramp(0, 7'h00, t);
         fchk("fade_out", t, c, 16);
      end
      end_sim();
   end
endmodule // lsb_timing_tb_top
